// file: hdl/paired_timer_pkg.sv
package paired_timer_pkg;

  // register byte offsets
  localparam logic [11:0] even_ctrl_off   = 12'h000;
  localparam logic [11:0] even_count_off  = 12'h004;
  localparam logic [11:0] even_period_off = 12'h008;
  localparam logic [11:0] odd_ctrl_off    = 12'h00C;
  localparam logic [11:0] odd_count_off   = 12'h010;
  localparam logic [11:0] odd_period_off  = 12'h014;
  localparam logic [11:0] status_off      = 12'h018;

  // control field positions
  localparam int run_enable_bit    = 15;
  localparam int idle_stop_bit     = 13;
  localparam int gate_enable_bit   = 6;
  localparam int prescale_lo_bit   = 4;
  localparam int pair_mode_bit     = 3;
  localparam int clock_source_bit  = 1;
  // writable bits of each control register; the rest read as zero
  localparam logic [15:0] even_ctrl_mask = 16'hA07A;
  localparam logic [15:0] odd_ctrl_mask  = 16'hA072;

  localparam logic [15:0] ctrl_reset   = 16'h0000;
  localparam logic [15:0] count_reset  = 16'h0000;
  localparam logic [15:0] period_reset = 16'hFFFF;

  // status bits: 0 even flag, 1 odd flag; write one to clear
  localparam int even_flag_bit = 0;
  localparam int odd_flag_bit  = 1;

endpackage : paired_timer_pkg

// file: hdl/paired_cascadable_timer.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module paired_cascadable_timer
  import paired_timer_pkg::*;
#(
  parameter int pair_index = 0
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device state and pins
  input  wire logic        idle_mode,
  input  wire logic        even_ext_clock_pin,
  input  wire logic        odd_ext_clock_pin,
  // interrupts to the controller
  output logic             even_irq,
  output logic             odd_irq,
  // triggers and time bases
  output logic             adc1_trigger,
  output logic             adc2_trigger,
  output logic             dma_trigger_even,
  output logic             dma_trigger_odd,
  output logic      [15:0] even_time_base,
  output logic      [15:0] odd_time_base
);

  logic [15:0] even_ctrl_q, odd_ctrl_q;
  logic [15:0] even_count_q, odd_count_q;
  logic [15:0] even_period_q, odd_period_q;
  logic        even_flag_q, odd_flag_q;
  logic [7:0]  even_pre_q, odd_pre_q;
  logic        even_pin_q, odd_pin_q;
  logic        even_tick, odd_tick;
  logic        even_gate_fall, odd_gate_fall;
  logic        even_match, odd_match, pair_match;
  logic        even_evt, odd_evt;
  logic        pair_mode;
  logic        wr_en, rd_en;

  function automatic logic [7:0] prescale_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: prescale_limit = 8'h00;
      2'b01: prescale_limit = 8'h07;
      2'b10: prescale_limit = 8'h3F;
      2'b11: prescale_limit = 8'hFF;
    endcase
  endfunction : prescale_limit

  // one timer's input clock pulse before prescaling
  function automatic logic raw_clock(input logic [15:0] ctrl, input logic pin,
                                     input logic pin_q);
    if (ctrl[clock_source_bit])
      raw_clock = pin & ~pin_q;
    else if (ctrl[gate_enable_bit])
      raw_clock = pin;
    else
      raw_clock = 1'b1;
  endfunction : raw_clock

  function automatic logic running(input logic [15:0] ctrl, input logic idle);
    running = ctrl[run_enable_bit] & ~(ctrl[idle_stop_bit] & idle);
  endfunction : running

  assign pair_mode = even_ctrl_q[pair_mode_bit];

  // external pins are taken as synchronous; one stage gives edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_pin_q <= 1'b0;
      odd_pin_q  <= 1'b0;
    end else begin
      even_pin_q <= even_ext_clock_pin;
      odd_pin_q  <= odd_ext_clock_pin;
    end
  end

  // gate falling edge counts only in gated internal-clock mode
  assign even_gate_fall = running(even_ctrl_q, idle_mode) & even_ctrl_q[gate_enable_bit]
                          & ~even_ctrl_q[clock_source_bit] & even_pin_q & ~even_ext_clock_pin;
  assign odd_gate_fall  = ~pair_mode & running(odd_ctrl_q, idle_mode)
                          & odd_ctrl_q[gate_enable_bit] & ~odd_ctrl_q[clock_source_bit]
                          & odd_pin_q & ~odd_ext_clock_pin;

  // even prescaler also drives the joined pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_pre_q <= 8'h00;
    end else if (!running(even_ctrl_q, idle_mode)) begin
      even_pre_q <= 8'h00;
    end else if (raw_clock(even_ctrl_q, even_ext_clock_pin, even_pin_q)) begin
      if (even_pre_q >= prescale_limit(even_ctrl_q[prescale_lo_bit +: 2]))
        even_pre_q <= 8'h00;
      else
        even_pre_q <= even_pre_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odd_pre_q <= 8'h00;
    end else if (pair_mode || !running(odd_ctrl_q, idle_mode)) begin
      odd_pre_q <= 8'h00;
    end else if (raw_clock(odd_ctrl_q, odd_ext_clock_pin, odd_pin_q)) begin
      if (odd_pre_q >= prescale_limit(odd_ctrl_q[prescale_lo_bit +: 2]))
        odd_pre_q <= 8'h00;
      else
        odd_pre_q <= odd_pre_q + 8'h01;
    end
  end

  assign even_tick = running(even_ctrl_q, idle_mode)
                     & raw_clock(even_ctrl_q, even_ext_clock_pin, even_pin_q)
                     & (even_pre_q >= prescale_limit(even_ctrl_q[prescale_lo_bit +: 2]));
  assign odd_tick  = ~pair_mode & running(odd_ctrl_q, idle_mode)
                     & raw_clock(odd_ctrl_q, odd_ext_clock_pin, odd_pin_q)
                     & (odd_pre_q >= prescale_limit(odd_ctrl_q[prescale_lo_bit +: 2]));

  assign even_match = even_count_q == even_period_q;
  assign odd_match  = odd_count_q == odd_period_q;
  assign pair_match = even_match & odd_match;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  // counters: a bus write loads, a tick advances or wraps on match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_count_q <= count_reset;
      odd_count_q  <= count_reset;
    end else begin
      if (wr_en && paddr == even_count_off)
        even_count_q <= pwdata[15:0];
      else if (even_tick)
        even_count_q <= (pair_mode ? pair_match : even_match) ? 16'h0000
                                                              : even_count_q + 16'h0001;
      if (wr_en && paddr == odd_count_off)
        odd_count_q <= pwdata[15:0];
      else if (pair_mode && even_tick)
        odd_count_q <= pair_match ? 16'h0000
                       : (even_count_q == 16'hFFFF ? odd_count_q + 16'h0001 : odd_count_q);
      else if (odd_tick)
        odd_count_q <= odd_match ? 16'h0000 : odd_count_q + 16'h0001;
    end
  end

  // events: pair mode routes everything to the odd flag
  assign even_evt = ~pair_mode & ((even_tick & even_match) | even_gate_fall);
  assign odd_evt  = pair_mode ? ((even_tick & pair_match) | even_gate_fall)
                              : ((odd_tick & odd_match) | odd_gate_fall);

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_flag_q <= 1'b0;
      odd_flag_q  <= 1'b0;
    end else begin
      if (even_evt)
        even_flag_q <= 1'b1;
      else if (wr_en && paddr == status_off && pwdata[even_flag_bit])
        even_flag_q <= 1'b0;
      if (odd_evt)
        odd_flag_q <= 1'b1;
      else if (wr_en && paddr == status_off && pwdata[odd_flag_bit])
        odd_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_ctrl_q   <= ctrl_reset;
      odd_ctrl_q    <= ctrl_reset;
      even_period_q <= period_reset;
      odd_period_q  <= period_reset;
    end else if (wr_en) begin
      unique case (paddr)
        even_ctrl_off:   even_ctrl_q   <= pwdata[15:0] & even_ctrl_mask;
        odd_ctrl_off:    odd_ctrl_q    <= pwdata[15:0] & odd_ctrl_mask;
        even_period_off: even_period_q <= pwdata[15:0];
        odd_period_off:  odd_period_q  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // read data registered in the setup cycle, so the access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      unique case (paddr)
        even_ctrl_off:   prdata <= {16'h0000, even_ctrl_q};
        odd_ctrl_off:    prdata <= {16'h0000, odd_ctrl_q};
        even_count_off:  prdata <= {16'h0000, even_count_q};
        odd_count_off:   prdata <= {16'h0000, odd_count_q};
        even_period_off: prdata <= {16'h0000, even_period_q};
        odd_period_off:  prdata <= {16'h0000, odd_period_q};
        status_off:      prdata <= {30'h0, odd_flag_q, even_flag_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(paddr == even_ctrl_off || paddr == odd_ctrl_off
                   || paddr == even_count_off || paddr == odd_count_off
                   || paddr == even_period_off || paddr == odd_period_off
                   || paddr == status_off);

  assign even_irq = even_flag_q;
  assign odd_irq  = odd_flag_q;

  // event strobes are one cycle long, registered to keep outputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc1_trigger     <= 1'b0;
      adc2_trigger     <= 1'b0;
      dma_trigger_even <= 1'b0;
      dma_trigger_odd  <= 1'b0;
    end else begin
      adc1_trigger     <= (pair_index == 0) & odd_evt;
      adc2_trigger     <= (pair_index == 1) & odd_evt;
      dma_trigger_even <= (pair_index == 0) & even_evt;
      dma_trigger_odd  <= (pair_index == 0) & odd_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_time_base <= 16'h0000;
      odd_time_base  <= 16'h0000;
    end else begin
      even_time_base <= (pair_index == 0) ? even_count_q : 16'h0000;
      odd_time_base  <= (pair_index == 0) ? odd_count_q : 16'h0000;
    end
  end

endmodule : paired_cascadable_timer
`default_nettype wire

// file: tb/timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module timer_chk
  import paired_timer_pkg::*;
#(
  parameter int pair_index = 0
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        idle_mode,
  input wire logic        even_ext_clock_pin,
  input wire logic        odd_ext_clock_pin,
  // events
  input wire logic        even_irq,
  input wire logic        odd_irq,
  input wire logic        adc1_trigger,
  input wire logic        adc2_trigger,
  input wire logic        dma_trigger_even,
  input wire logic        dma_trigger_odd,
  input wire logic [15:0] even_time_base,
  input wire logic [15:0] odd_time_base
);
  logic acc;
  logic mapped;
  logic clr_w;
  assign acc    = psel && penable;
  assign mapped = paddr <= status_off && paddr[1:0] == 2'h0;
  assign clr_w  = acc && pwrite && paddr == status_off;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  slverr_map_a: assert property (acc && !mapped |-> pslverr) else $error("no slverr");
  slverr_ok_a: assert property (acc && mapped |-> !pslverr) else $error("bad slverr");
  ctrl_zero_a: assert property (acc && !pwrite && paddr == even_ctrl_off |->
    (prdata & 32'hFFFF5F85) == 32'h0) else $error("unused ctrl bit set");
  even_hold_a: assert property (even_irq && !(clr_w && pwdata[0]) |=> even_irq)
    else $error("even flag dropped");
  odd_hold_a: assert property (odd_irq && !(clr_w && pwdata[1]) |=> odd_irq)
    else $error("odd flag dropped");
  adc_pulse_a: assert property (adc1_trigger |=> !adc1_trigger) else $error("adc wide");
  adc_cause_a: assert property (adc1_trigger |-> even_irq || odd_irq)
    else $error("adc without event");
  adc2_none_a: assert property (pair_index != 1 |-> !adc2_trigger) else $error("adc2");
  dma_none_a: assert property (pair_index != 0 |-> !dma_trigger_even && !dma_trigger_odd
    && even_time_base == 16'h0000) else $error("dma or time base on other pair");
  cover property ($rose(even_irq));
  cover property ($rose(odd_irq));
  cover property (adc1_trigger);
endmodule : timer_chk
bind paired_cascadable_timer timer_chk #(.pair_index(pair_index)) i_chk (.*);
`default_nettype wire

// file: tb/paired_cascadable_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module paired_cascadable_timer_tb;
  import paired_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, idle_mode, ext_run, gate_lvl;
  logic        even_pin, odd_pin, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] etb, otb;
  logic        ev_irq, od_irq, clr_seen;
  logic [3:0]  seen, trig;
  logic [15:0] pe [4] = '{16'd2048, 16'd256, 16'd32, 16'd8};
  int          miscompares = 0;
  int          tests_run = 0;
  paired_cascadable_timer #(.pair_index(0)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .even_ext_clock_pin(even_pin), .odd_ext_clock_pin(odd_pin),
    .even_irq(ev_irq), .odd_irq(od_irq), .adc1_trigger(trig[3]), .adc2_trigger(trig[2]),
    .dma_trigger_even(trig[1]), .dma_trigger_odd(trig[0]), .even_time_base(etb),
    .odd_time_base(otb));
  // sticky record of trigger pulses, cleared by the bench before each match run
  always @(posedge pclk) seen <= clr_seen ? 4'h0 : (seen | trig);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // toggling gives one rising edge every two cycles
  always @(posedge pclk) even_pin <= ext_run ? ~even_pin : gate_lvl;
  always @(posedge pclk) odd_pin <= ~gate_lvl;
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    apb(1'b1, a, {16'h0000, d}, r);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, v);
  endtask : rd
  // stop edge still counts, so a run spans 2048 count clocks; one tick of slack
  task automatic run_for(input logic [15:0] c, input logic [15:0] e);
    wr(even_count_off, 16'h0000);
    wr(even_ctrl_off, c);
    repeat (2045) @(posedge pclk);
    wr(even_ctrl_off, 16'h0000);
    rd(even_count_off);
    `CHK(v[15:0] - e + 16'h0001 <= 16'h0002, 1'b1)
    `CHK(etb, v[15:0])
  endtask : run_for
  task automatic match(input logic [15:0] c, input logic [15:0] ep, input logic [15:0] op,
                       input logic [31:0] e);
    wr(status_off, 16'h0003);
    clr_seen <= 1'b1;
    @(posedge pclk);
    clr_seen <= 1'b0;
    wr(even_count_off, 16'h0000);
    wr(odd_count_off, 16'h0000);
    wr(even_period_off, ep);
    wr(odd_period_off, op);
    wr(even_ctrl_off, c);
    repeat (10) @(posedge pclk);
    wr(even_ctrl_off, 16'h0000);
    rd(status_off);
    `CHK(v, e)
    `CHK({od_irq, ev_irq}, e[1:0])
    `CHK(seen, {e[1], 1'b0, e[0], e[1]})
  endtask : match
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, idle_mode, ext_run, gate_lvl} = 7'h00;
    {paddr, pwdata, even_pin, odd_pin, clr_seen} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(even_ctrl_off);
    `CHK(v, 32'h00000000)
    rd(odd_period_off);
    `CHK(v, 32'h0000FFFF)
    wr(even_ctrl_off, 16'h7FFF);
    rd(even_ctrl_off);
    `CHK(v, 32'h0000207A)
    wr(odd_ctrl_off, 16'h7FFF);
    rd(odd_ctrl_off);
    `CHK(v, 32'h00002072)
    rd(12'h01C);
    `CHK(v, 32'h00000000)
    wr(even_ctrl_off, 16'h0000);
    wr(odd_ctrl_off, 16'h0000);
    for (int i = 0; i < 4; i++) run_for(16'h8000 | (16'(i) << 4), pe[i]);
    idle_mode <= 1'b1;
    run_for(16'hA000, 16'd0);
    run_for(16'h8000, 16'd2048);
    idle_mode <= 1'b0;
    ext_run <= 1'b1;
    run_for(16'h8002, 16'd1024);
    run_for(16'h8042, 16'd1024);
    run_for(16'h800A, 16'd1024);
    ext_run  <= 1'b0;
    gate_lvl <= 1'b1;
    run_for(16'h8040, 16'd2048);
    gate_lvl <= 1'b0;
    run_for(16'h8040, 16'd0);
    wr(status_off, 16'h0003);
    gate_lvl <= 1'b1;
    wr(even_ctrl_off, 16'h8040);
    gate_lvl <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(even_ctrl_off, 16'h0000);
    rd(status_off);
    `CHK(v, 32'h00000001)
    wr(even_count_off, 16'hFFFE);
    wr(even_ctrl_off, 16'h8008);
    wr(even_ctrl_off, 16'h0008);
    rd(odd_count_off);
    `CHK(v, 32'h00000001)
    `CHK(otb, 16'h0001)
    match(16'h8000, 16'h0002, 16'hFFFF, 32'h00000001);
    match(16'h8008, 16'h0003, 16'h0000, 32'h00000002);
    match(16'h8008, 16'h0000, 16'h0001, 32'h00000000);
    final_report();
  end
endmodule : paired_cascadable_timer_tb
`default_nettype wire
